// >>> tlbrw_pkg.sv
// Shared constants and types for the TLB maintenance path
package tlbrw_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int TLB_ENTRIES = 16;
  localparam int IDX_W = 4;
  localparam int VIRTUAL_PAGE_PAIR_W = 19;
  localparam int ADDRESS_SPACE_TAG_W = 8;
  localparam int MASK_W = 12;
  localparam int PFN_W = 20;
  localparam int CA_W = 3;
  localparam int APB_ADDR_W = 8;
  localparam int IRQ_W = 2;
  localparam int CMD_W = 2;
  localparam logic [IDX_W-1:0] RND_RESET = 4'hF;
  localparam logic [IDX_W-1:0] RND_LAST = 4'h0;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [APB_ADDR_W-1:0] OFF_ENTRY_HIGH = 8'h00;
  localparam logic [APB_ADDR_W-1:0] OFF_EVEN_LOW = 8'h04;
  localparam logic [APB_ADDR_W-1:0] OFF_ODD_LOW = 8'h08;
  localparam logic [APB_ADDR_W-1:0] OFF_PAGE_SIZE = 8'h0C;
  localparam logic [APB_ADDR_W-1:0] OFF_INDEX = 8'h10;
  localparam logic [APB_ADDR_W-1:0] OFF_RANDOM = 8'h14;
  localparam logic [APB_ADDR_W-1:0] OFF_MODE = 8'h18;
  localparam logic [APB_ADDR_W-1:0] OFF_COMMAND = 8'h1C;
  localparam logic [APB_ADDR_W-1:0] OFF_IRQ_STATUS = 8'h20;
  localparam logic [APB_ADDR_W-1:0] OFF_IRQ_ENABLE = 8'h24;
  localparam logic [APB_ADDR_W-1:0] OFF_IRQ_CLEAR = 8'h28;

  // ****************************************************************
  // Field positions and writable masks
  // ****************************************************************
  localparam int HI_VIRTUAL_PAGE_PAIR_LSB = 13;
  localparam int HI_ADDRESS_SPACE_TAG_LSB = 0;
  localparam int LO_PFN_LSB = 6;
  localparam int LO_C_LSB = 3;
  localparam int LO_D_BIT = 2;
  localparam int LO_V_BIT = 1;
  localparam int LO_G_BIT = 0;
  localparam int PM_MASK_LSB = 13;
  localparam logic [31:0] HI_WMASK = 32'hFFFFE0FF;
  localparam logic [31:0] LO_WMASK = 32'h03FFFFFF;
  localparam logic [31:0] PM_WMASK = 32'h01FFE000;
  localparam int MODE_CU0_BIT = 0;
  localparam int MODE_UM_BIT = 1;
  localparam int MODE_EXL_BIT = 2;
  localparam int MODE_ERL_BIT = 3;
  localparam int MODE_BAT_BIT = 4;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_UNUSABLE_BIT = 1;

  // ****************************************************************
  // Commands, states and carriers
  // ****************************************************************
  localparam logic [CMD_W-1:0] CMD_NONE = 2'h0;
  localparam logic [CMD_W-1:0] CMD_READ = 2'h1;
  localparam logic [CMD_W-1:0] CMD_WRITE_IDX = 2'h2;
  localparam logic [CMD_W-1:0] CMD_WRITE_RND = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_FIN = 2'b11
  } tlbrw_state_t;

  typedef struct packed {
    logic cp0_usable;
    logic user_mode_flag;
    logic exception_level;
    logic error_level;
  } tlbrw_priv_t;

  typedef struct packed {
    logic [MASK_W-1:0] mask;
    logic [VIRTUAL_PAGE_PAIR_W-1:0] virtual_page_pair;
    logic [ADDRESS_SPACE_TAG_W-1:0] address_space_tag;
    logic g;
    logic [PFN_W-1:0] physical_frame1;
    logic [CA_W-1:0] c1;
    logic d1;
    logic v1;
    logic [PFN_W-1:0] physical_frame0;
    logic [CA_W-1:0] c0;
    logic d0;
    logic v0;
  } tlbrw_entry_t;

endpackage

// >>> tlbrw_tlb_array.sv
// TLB entry storage with one write port and one read port
`timescale 1ns/1ps
module tlbrw_tlb_array import tlbrw_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Write port
  input wire logic we,
  input wire logic [IDX_W-1:0] widx,
  input wire tlbrw_entry_t wdata,
  // Read port
  input wire logic [IDX_W-1:0] ridx,
  output tlbrw_entry_t rdata
);

  tlbrw_entry_t entries [TLB_ENTRIES];

  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < TLB_ENTRIES; i++) begin
      if (reset) begin
        entries[i] <= '0;
      end else if (we && widx == IDX_W'(i)) begin
        entries[i] <= wdata;
      end
    end
  end

  assign rdata = entries[ridx];

  entry_load_a: assert property (@(posedge ref_clk) disable iff (reset)
    we |=> entries[$past(widx)] == $past(wdata))
    else $error("TLB entry not loaded with write data");

endmodule // tlbrw_tlb_array

// >>> tlbrw_replace_ptr.sv
// Free-running replacement pointer for random writes
`timescale 1ns/1ps
module tlbrw_replace_ptr import tlbrw_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Pointer
  output logic [IDX_W-1:0] rnd_ptr
);

  logic [IDX_W-1:0] ptr_reg;
  logic [IDX_W-1:0] ptr_next;

  // Counts down and wraps to the top entry, never past the array
  always_comb begin
    if (ptr_reg == RND_LAST) begin
      ptr_next = RND_RESET;
    end else begin
      ptr_next = ptr_reg - IDX_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ptr_reg <= RND_RESET;
    end else begin
      ptr_reg <= ptr_next;
    end
  end

  assign rnd_ptr = ptr_reg;

  ptr_in_range_a: assert property (@(posedge ref_clk) disable iff (reset)
    (32'(ptr_reg) < TLB_ENTRIES) and
    (ptr_reg == RND_LAST |=> ptr_reg == RND_RESET))
    else $error("Replacement pointer left the entry range");

endmodule // tlbrw_replace_ptr

// >>> tlbrw_maint.sv
// TLB entry read and write maintenance block with APB registers
`timescale 1ns/1ps
module tlbrw_maint import tlbrw_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Events
  output logic irq,
  output logic cp0_unusable_exc
);

  // ****************************************************************
  // Decoding functions
  // ****************************************************************
  function automatic logic op_allowed(input tlbrw_priv_t p);
    op_allowed = p.cp0_usable || !p.user_mode_flag ||
                 p.exception_level || p.error_level;
  endfunction

  function automatic logic addr_mapped(input logic [APB_ADDR_W-1:0] a);
    case (a)
      OFF_ENTRY_HIGH, OFF_EVEN_LOW, OFF_ODD_LOW, OFF_PAGE_SIZE,
      OFF_INDEX, OFF_RANDOM, OFF_MODE, OFF_COMMAND,
      OFF_IRQ_STATUS, OFF_IRQ_ENABLE, OFF_IRQ_CLEAR: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] pack_low(
    input logic [PFN_W-1:0] physical_frame,
    input logic [CA_W-1:0] ca,
    input logic d,
    input logic v,
    input logic g
  );
    logic [31:0] w;
    w = '0;
    w[LO_PFN_LSB +: PFN_W] = physical_frame;
    w[LO_C_LSB +: CA_W] = ca;
    w[LO_D_BIT] = d;
    w[LO_V_BIT] = v;
    w[LO_G_BIT] = g;
    pack_low = w;
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [31:0] entry_high_reg;
  logic [31:0] even_page_low_reg;
  logic [31:0] odd_page_low_reg;
  logic [31:0] page_size_reg;
  logic [IDX_W-1:0] index_reg;
  tlbrw_priv_t priv_reg;
  logic bat_mode_reg;
  logic [CMD_W-1:0] cmd_reg;
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_enable_reg;
  logic [IRQ_W-1:0] irq_set;
  logic [31:0] prdata_reg;
  logic [31:0] rd_mux;
  logic exc_reg;
  tlbrw_state_t state_reg;
  tlbrw_state_t state_next;
  logic wr_access;
  logic cmd_write;
  logic exec_ok;
  logic exec_bad;
  logic do_read;
  logic tlb_we;
  logic [IDX_W-1:0] tlb_widx;
  logic [IDX_W-1:0] rnd_ptr;
  tlbrw_entry_t tlb_wdata;
  tlbrw_entry_t rd_entry;
  logic [VIRTUAL_PAGE_PAIR_W-1:0] virtual_page_pair_masked;

  // ****************************************************************
  // Submodules
  // ****************************************************************
  tlbrw_tlb_array tlbrw_tlb_array_i (
    .ref_clk(ref_clk),
    .reset(reset),
    .we(tlb_we),
    .widx(tlb_widx),
    .wdata(tlb_wdata),
    .ridx(index_reg),
    .rdata(rd_entry)
  );

  tlbrw_replace_ptr tlbrw_replace_ptr_i (
    .ref_clk(ref_clk),
    .reset(reset),
    .rnd_ptr(rnd_ptr)
  );

  // ****************************************************************
  // APB handshake
  // ****************************************************************
  // Bus waits while an op runs so staging regs never see two writers
  assign pready = (state_reg == ST_IDLE);
  assign pslverr = psel && penable && pready && !addr_mapped(paddr);
  assign wr_access = psel && penable && pready && pwrite;
  assign cmd_write = wr_access && paddr == OFF_COMMAND &&
                     pwdata[CMD_W-1:0] != CMD_NONE;
  assign prdata = prdata_reg;

  always_comb begin
    rd_mux = '0;
    case (paddr)
      OFF_ENTRY_HIGH: rd_mux = entry_high_reg;
      OFF_EVEN_LOW: rd_mux = even_page_low_reg;
      OFF_ODD_LOW: rd_mux = odd_page_low_reg;
      OFF_PAGE_SIZE: rd_mux = page_size_reg;
      OFF_INDEX: rd_mux = {{(32-IDX_W){1'b0}}, index_reg};
      OFF_RANDOM: rd_mux = {{(32-IDX_W){1'b0}}, rnd_ptr};
      OFF_MODE: begin
        rd_mux[MODE_CU0_BIT] = priv_reg.cp0_usable;
        rd_mux[MODE_UM_BIT] = priv_reg.user_mode_flag;
        rd_mux[MODE_EXL_BIT] = priv_reg.exception_level;
        rd_mux[MODE_ERL_BIT] = priv_reg.error_level;
        rd_mux[MODE_BAT_BIT] = bat_mode_reg;
      end
      OFF_IRQ_STATUS: rd_mux = {{(32-IRQ_W){1'b0}}, irq_status_reg};
      OFF_IRQ_ENABLE: rd_mux = {{(32-IRQ_W){1'b0}}, irq_enable_reg};
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prdata_reg <= '0;
    end else if (psel && !pwrite) begin
      prdata_reg <= rd_mux;
    end
  end

  // ****************************************************************
  // Op sequencer
  // ****************************************************************
  always_comb begin
    case (state_reg)
      ST_IDLE: state_next = cmd_write ? ST_EXEC : ST_IDLE;
      ST_EXEC: state_next = ST_FIN;
      ST_FIN: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cmd_reg <= CMD_NONE;
    end else if (cmd_write) begin
      cmd_reg <= pwdata[CMD_W-1:0];
    end
  end
  assign exec_ok = state_reg == ST_EXEC && op_allowed(priv_reg);
  assign exec_bad = state_reg == ST_EXEC && !op_allowed(priv_reg);
  assign do_read = exec_ok && cmd_reg == CMD_READ;
  // ****************************************************************
  // Entry write path
  // ****************************************************************
  assign tlb_we = exec_ok && (cmd_reg == CMD_WRITE_IDX ||
                              cmd_reg == CMD_WRITE_RND);
  assign tlb_widx = (cmd_reg == CMD_WRITE_RND) ? rnd_ptr : index_reg;

  always_comb begin
    tlb_wdata.mask = page_size_reg[PM_MASK_LSB +: MASK_W];
    tlb_wdata.virtual_page_pair = entry_high_reg[HI_VIRTUAL_PAGE_PAIR_LSB +: VIRTUAL_PAGE_PAIR_W];
    tlb_wdata.address_space_tag = entry_high_reg[HI_ADDRESS_SPACE_TAG_LSB +: ADDRESS_SPACE_TAG_W];
    tlb_wdata.g = even_page_low_reg[LO_G_BIT] &
                  odd_page_low_reg[LO_G_BIT];
    tlb_wdata.physical_frame1 = odd_page_low_reg[LO_PFN_LSB +: PFN_W];
    tlb_wdata.c1 = odd_page_low_reg[LO_C_LSB +: CA_W];
    tlb_wdata.d1 = odd_page_low_reg[LO_D_BIT];
    tlb_wdata.v1 = odd_page_low_reg[LO_V_BIT];
    tlb_wdata.physical_frame0 = even_page_low_reg[LO_PFN_LSB +: PFN_W];
    tlb_wdata.c0 = even_page_low_reg[LO_C_LSB +: CA_W];
    tlb_wdata.d0 = even_page_low_reg[LO_D_BIT];
    tlb_wdata.v0 = even_page_low_reg[LO_V_BIT];
  end

  // ****************************************************************
  // Staging registers
  // ****************************************************************
  assign virtual_page_pair_masked = rd_entry.virtual_page_pair &
    ~{{(VIRTUAL_PAGE_PAIR_W-MASK_W){1'b0}}, rd_entry.mask};

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      entry_high_reg <= '0;
    end else if (do_read) begin
      entry_high_reg <= '0;
      entry_high_reg[HI_VIRTUAL_PAGE_PAIR_LSB +: VIRTUAL_PAGE_PAIR_W] <= virtual_page_pair_masked;
      entry_high_reg[HI_ADDRESS_SPACE_TAG_LSB +: ADDRESS_SPACE_TAG_W] <= bat_mode_reg ?
        '0 : rd_entry.address_space_tag;
    end else if (wr_access && paddr == OFF_ENTRY_HIGH) begin
      entry_high_reg <= pwdata & HI_WMASK;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      even_page_low_reg <= '0;
    end else if (do_read) begin
      even_page_low_reg <= pack_low(rd_entry.physical_frame0, rd_entry.c0,
        rd_entry.d0, rd_entry.v0, rd_entry.g);
    end else if (wr_access && paddr == OFF_EVEN_LOW) begin
      even_page_low_reg <= pwdata & LO_WMASK;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      odd_page_low_reg <= '0;
    end else if (do_read) begin
      odd_page_low_reg <= pack_low(rd_entry.physical_frame1, rd_entry.c1,
        rd_entry.d1, rd_entry.v1, rd_entry.g);
    end else if (wr_access && paddr == OFF_ODD_LOW) begin
      odd_page_low_reg <= pwdata & LO_WMASK;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      page_size_reg <= '0;
    end else if (do_read) begin
      page_size_reg <= '0;
      page_size_reg[PM_MASK_LSB +: MASK_W] <= rd_entry.mask;
    end else if (wr_access && paddr == OFF_PAGE_SIZE) begin
      page_size_reg <= pwdata & PM_WMASK;
    end
  end
  // Index holds only enough bits to address the array's 16 entries
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      index_reg <= '0;
    end else if (wr_access && paddr == OFF_INDEX) begin
      index_reg <= pwdata[IDX_W-1:0];
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      priv_reg <= '0;
      bat_mode_reg <= 1'b0;
    end else if (wr_access && paddr == OFF_MODE) begin
      priv_reg.cp0_usable <= pwdata[MODE_CU0_BIT];
      priv_reg.user_mode_flag <= pwdata[MODE_UM_BIT];
      priv_reg.exception_level <= pwdata[MODE_EXL_BIT];
      priv_reg.error_level <= pwdata[MODE_ERL_BIT];
      bat_mode_reg <= pwdata[MODE_BAT_BIT];
    end
  end

  // ****************************************************************
  // Exception and interrupts
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      exc_reg <= 1'b0;
    end else begin
      exc_reg <= exec_bad;
    end
  end
  assign cp0_unusable_exc = exc_reg;
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_DONE_BIT] = state_reg == ST_FIN;
    irq_set[IRQ_UNUSABLE_BIT] = exec_bad;
  end
  // A new event in the clearing cycle survives the clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_status_reg <= '0;
    end else if (wr_access && paddr == OFF_IRQ_CLEAR) begin
      irq_status_reg <= (irq_status_reg & ~pwdata[IRQ_W-1:0]) | irq_set;
    end else begin
      irq_status_reg <= irq_status_reg | irq_set;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_enable_reg <= '0;
    end else if (wr_access && paddr == OFF_IRQ_ENABLE) begin
      irq_enable_reg <= pwdata[IRQ_W-1:0];
    end
  end
  assign irq = |(irq_status_reg & irq_enable_reg);

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence op_run_s;
    state_reg == ST_EXEC ##1 state_reg == ST_FIN ##1 state_reg == ST_IDLE;
  endsequence
  sequence refused_s;
    cp0_unusable_exc ##1 !cp0_unusable_exc;
  endsequence
  op_sequence_a: assert property (
    cmd_write |=> op_run_s)
    else $error("Op did not run exec, finish, idle");
  read_copy_a: assert property (
    do_read |=> page_size_reg[PM_MASK_LSB +: MASK_W] == $past(rd_entry.mask)
      && odd_page_low_reg[LO_PFN_LSB +: PFN_W] ==
         $past(rd_entry.physical_frame1))
    else $error("Read did not copy entry to staging");
  vpn_masked_a: assert property (
    do_read |=> (entry_high_reg[HI_VIRTUAL_PAGE_PAIR_LSB +: MASK_W] &
                 page_size_reg[PM_MASK_LSB +: MASK_W]) == '0)
    else $error("Page pair bits not cleared under mask");
  shared_copy_a: assert property (
    do_read |=> even_page_low_reg[LO_G_BIT] == $past(rd_entry.g) &&
                odd_page_low_reg[LO_G_BIT] == $past(rd_entry.g))
    else $error("Shared bit not copied to both low regs");
  bat_tag_zero_a: assert property (
    do_read && bat_mode_reg |=>
      entry_high_reg[HI_ADDRESS_SPACE_TAG_LSB +: ADDRESS_SPACE_TAG_W] == '0)
    else $error("Space tag not zero in block translation mode");
  priv_gate_a: assert property (
    tlb_we || do_read |-> priv_reg.cp0_usable ||
      !priv_reg.user_mode_flag || priv_reg.exception_level ||
      priv_reg.error_level)
    else $error("Op ran without privilege");
  refused_op_a: assert property (
    exec_bad |-> !tlb_we ##1 (refused_s and $stable(entry_high_reg) and
      $stable(even_page_low_reg) and $stable(odd_page_low_reg) and
      $stable(page_size_reg)))
    else $error("Refused op changed state or gave no exception");
  idx_write_a: assert property (
    exec_ok && cmd_reg == CMD_WRITE_IDX |-> tlb_we && tlb_widx == index_reg)
    else $error("Indexed write missed its entry");
  rnd_write_a: assert property (
    exec_ok && cmd_reg == CMD_WRITE_RND |-> tlb_we && tlb_widx == rnd_ptr)
    else $error("Random write missed replacement entry");
  shared_merge_a: assert property (
    tlb_we |-> tlb_wdata.g == (even_page_low_reg[LO_G_BIT] &
                               odd_page_low_reg[LO_G_BIT]))
    else $error("Stored shared bit is not the AND");

endmodule // tlbrw_maint

// >>> tlbrw_apb_master.sv
// APB master model standing in for the pipeline that issues TLB ops
`timescale 1ns/1ps
module tlbrw_apb_master import tlbrw_pkg::*; (
  // Clock
  input wire logic ref_clk,
  // APB request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [APB_ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  // APB answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ****************************************************************
  // Idle bus
  // ****************************************************************
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end

  // ****************************************************************
  // One transfer; callers only target a 16-entry TLB core
  // ****************************************************************
  task automatic xfer(input logic w, input logic [APB_ADDR_W-1:0] a,
    input logic [31:0] d, output logic [31:0] rd, output logic err);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Waits as long as the slave stalls; only the bench watchdog ends it
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines stop showing the last request
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // tlbrw_apb_master

// >>> tlbrw_maint_test.sv
// Self-checking testbench of the TLB maintenance block
`timescale 1ns/1ps
module tlbrw_maint_test import tlbrw_pkg::*; ();
  // ****************************************************************
  // Signals and stimulus values
  // ****************************************************************
  logic ref_clk, reset, psel, penable, pwrite, pready, pslverr;
  logic irq, cp0_unusable_exc;
  logic [APB_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  int n_errors = 0;
  int tests_run = 0;
  int n_exc = 0;
  localparam logic [31:0] HI = 32'hABCDE0C3;
  localparam logic [31:0] HI2 = 32'h12344001;
  localparam logic [31:0] LO0 = 32'h01234567;
  localparam logic [31:0] LO1 = 32'h02468ACE;
  localparam logic [31:0] PM = 32'h00006000;
  localparam logic [31:0] JUNK = 32'h000000FF;

  tlbrw_maint tlbrw_maint_i (.ref_clk(ref_clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .cp0_unusable_exc(cp0_unusable_exc));
  tlbrw_apb_master tlbrw_apb_master_i (.ref_clk(ref_clk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Counts exception pulses
  always @(posedge ref_clk) begin
    if (cp0_unusable_exc === 1'b1) n_exc <= n_exc + 1;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic irq_chk(input logic exp);
    @(negedge ref_clk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    tlbrw_apb_master_i.xfer(1'b1, a, d, r, e);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    tlbrw_apb_master_i.xfer(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask
  task automatic op(input logic [CMD_W-1:0] c);
    wr(OFF_COMMAND, {30'h0, c});
  endtask
  task automatic stage(input logic [31:0] h, l0, l1, p);
    wr(OFF_ENTRY_HIGH, h);
    wr(OFF_EVEN_LOW, l0);
    wr(OFF_ODD_LOW, l1);
    wr(OFF_PAGE_SIZE, p);
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    $display("watchdog expired");
    end_of_test();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    int hits;
    logic [31:0] r;
    logic e;
    reset = 1'b1;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    // Reset values of every register but the running pointer
    for (int i = 0; i <= 10; i++) begin
      if (i != 5) rchk(8'(i * 4), 32'h0);
    end
    irq_chk(1'b0);
    done("reset");
    stage(HI, LO0, LO1, PM);
    wr(OFF_INDEX, 32'h5);
    op(CMD_WRITE_IDX);
    stage(32'h0, 32'h0, 32'h0, 32'h0);
    op(CMD_READ);
    rchk(OFF_ENTRY_HIGH, HI & ~PM);
    rchk(OFF_EVEN_LOW, LO0 & ~32'h1);
    rchk(OFF_ODD_LOW, LO1);
    rchk(OFF_PAGE_SIZE, PM);
    done("indexed");
    wr(OFF_IRQ_CLEAR, 32'h3);
    wr(OFF_IRQ_ENABLE, 32'h2);
    // Only user mode without any override is refused
    for (int m = 0; m < 16; m++) begin
      wr(OFF_MODE, 32'(m));
      wr(OFF_ENTRY_HIGH, JUNK);
      op(CMD_READ);
      rchk(OFF_ENTRY_HIGH, (m == 2) ? JUNK : (HI & ~PM));
    end
    chk(32'(n_exc), 32'h1);
    irq_chk(1'b1);
    rchk(OFF_IRQ_STATUS, 32'h3);
    wr(OFF_IRQ_CLEAR, 32'h2);
    irq_chk(1'b0);
    wr(OFF_IRQ_ENABLE, 32'h1);
    irq_chk(1'b1);
    wr(OFF_IRQ_CLEAR, 32'h1);
    rchk(OFF_IRQ_STATUS, 32'h0);
    irq_chk(1'b0);
    done("privilege");
    wr(OFF_MODE, 32'h10);
    op(CMD_READ);
    rchk(OFF_ENTRY_HIGH, HI & ~PM & ~32'hFF);
    done("block translation");
    wr(OFF_MODE, 32'h0);
    stage(HI2, LO0, LO1 | 32'h1, PM);
    op(CMD_WRITE_RND);
    hits = 0;
    for (int i = 0; i < 16; i++) begin
      wr(OFF_INDEX, 32'(i));
      op(CMD_READ);
      tlbrw_apb_master_i.xfer(1'b0, OFF_ENTRY_HIGH, 32'h0, r, e);
      if (r === (HI2 & ~PM)) begin
        hits++;
        rchk(OFF_ODD_LOW, LO1 | 32'h1);
        rchk(OFF_EVEN_LOW, LO0);
      end
    end
    chk(32'(hits), 32'h1);
    done("random");
    tlbrw_apb_master_i.xfer(1'b0, 8'h30, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    tlbrw_apb_master_i.xfer(1'b1, OFF_RANDOM, 32'h0, r, e);
    chk({31'h0, e}, 32'h0);
    wr(OFF_IRQ_CLEAR, 32'h3);
    wr(OFF_IRQ_STATUS, 32'h3);
    op(CMD_NONE);
    rchk(OFF_IRQ_STATUS, 32'h0);
    rchk(OFF_COMMAND, 32'h0);
    done("access kinds");
    end_of_test();
  end
endmodule // tlbrw_maint_test
